//--- design/fwp_core.sv
// write-protect, lock-down, security-ID, pause and status logic
`timescale 1ns/1ps
module fwp_core
    import fwp_pkg::*;
#(
    parameter logic [63:0] UNIQUE_ID = 64'h0123_4567_89ab_cdef // arbitrary value
)(
    input  wire logic        clock,
    input  wire logic        rstn,
    input  wire logic        factory_rstn,
    input  wire logic        clk_en,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        protect_pin_n,
    input  wire logic        pause_pin_n,
    input  wire logic        chip_sel_n,
    input  wire logic        serial_clk,
    input  wire logic        so_data,
    input  wire logic        so_drive,
    output logic             so_out,
    output logic             so_oe,
    output logic             serial_frozen,
    output logic             link_reset
);

    // pin synchronisers, stage [1] is the only one read
    logic [1:0] wp_sync_q;
    logic [1:0] pause_sync_q;
    logic [1:0] cs_sync_q;
    logic [1:0] sck_sync_q;
    logic       cs_prev_q;

    // bus slave
    logic        ack_q;
    logic [31:0] dat_q;
    logic [31:0] rdata;
    logic [31:0] wmask;
    logic        wb_req;
    logic        wb_wr;

    // command path
    logic        cmd_vld;
    logic [7:0]  cmd_code;
    logic        cmd_ok;
    logic        go;
    logic        refused_q;

    // protection state
    logic             wel_q;
    logic             lockdown_q;
    logic             ioc_q;
    logic             quad_q;
    logic             pin_en_q;
    logic             sid_lock_q;
    logic [PLOCK_W-1:0] plock_q;
    logic [BPR_W-1:0]   bpr_q;
    logic [7:0]       cfg_stage_q;
    logic [31:0]      stage_q [BPR_WORDS];
    logic [31:0]      sid_q [SID_WORDS];
    logic [31:0]      sid_data_q;
    logic [8:0]       index_q;
    logic [BPR_WORDS*32-1:0] stage_all;
    logic [BPR_WORDS*32-1:0] bpr_all;
    logic [BPR_WORDS*32-1:0] plock_all;

    // operation sequencer
    fwp_state_t       state_q;
    logic [TMR_W-1:0] tmr_q;
    logic             sid_op_q;
    logic             busy;
    logic             op_done;

    // derived conditions
    logic       wp_active;
    logic       blk_locked;
    logic       idx_bpr;
    logic       hold_en;
    logic       hold_q;
    logic       hold_reset;
    logic [7:0] status;

    // pins come from another domain, two flops each
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            wp_sync_q    <= 2'h3;
            pause_sync_q <= 2'h3;
            cs_sync_q    <= 2'h3;
            sck_sync_q   <= 2'h0;
            cs_prev_q    <= 1'b1;
        end else if (clk_en) begin
            wp_sync_q    <= {wp_sync_q[0], protect_pin_n};
            pause_sync_q <= {pause_sync_q[0], pause_pin_n};
            cs_sync_q    <= {cs_sync_q[0], chip_sel_n};
            sck_sync_q   <= {sck_sync_q[0], serial_clk};
            cs_prev_q    <= cs_sync_q[1];
        end
    end

    // classic single-cycle slave: ack one cycle after the strobe, writes act at ack
    assign wb_req   = wb_cyc_i & wb_stb_i;
    assign wb_wr    = wb_req & wb_we_i & ack_q;
    assign wmask    = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign cmd_vld  = wb_wr && (wb_adr_i == OFS_CMD) && wb_sel_i[0];
    assign cmd_code = wb_dat_i[7:0];

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ack_q <= 1'b0;
            dat_q <= 32'h0000_0000;
        end else if (clk_en) begin
            ack_q <= wb_req & ~ack_q;
            if (wb_req && !ack_q) begin
                dat_q <= rdata;
            end
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;

    // wide registers flattened for word access
    for (genvar g = 0; g < BPR_WORDS; g++) begin : g_words
        assign stage_all[g*32 +: 32] = stage_q[g];
    end
    assign bpr_all   = {16'h0000, bpr_q};
    assign plock_all = {24'h00_0000, plock_q};
    assign idx_bpr   = index_q < 9'(BPR_WORDS);

    // hardware protect only in single/dual mode with io bit clear
    assign wp_active = ~wp_sync_q[1] & ~ioc_q & pin_en_q & ~quad_q;

    // program/erase target is the block selected by the index
    assign blk_locked = (index_q < 9'(PLOCK_W)) ? bpr_q[index_q[7:0]] : 1'b0;

    assign busy    = (state_q == FWP_PROG) || (state_q == FWP_ERASE) || (state_q == FWP_NV);
    assign op_done = busy && (tmr_q == TMR_W'(1));

    // busy duplicated at both ends of the status byte
    assign status = {busy, 1'b0, sid_lock_q, lockdown_q,
                     state_q == FWP_PSUS, state_q == FWP_ESUS, wel_q, busy};

    // read mux, unmapped addresses read as zero
    always_comb begin
        rdata = 32'h0000_0000;
        case (wb_adr_i)
            OFS_STATUS: rdata[7:0] = status;
            OFS_CONFIG: begin
                rdata[CFG_IOC]    = ioc_q;
                rdata[CFG_VOLAT]  = ~|plock_q;
                rdata[CFG_PIN_EN] = pin_en_q;
            end
            OFS_CMD: begin
                rdata[CMD_REFUSED] = refused_q;
                rdata[CMD_QUAD]    = quad_q;
            end
            OFS_INDEX:  rdata[8:0] = index_q;
            OFS_BPR:    rdata = idx_bpr ? bpr_all[index_q[2:0]*32 +: 32] : 32'h0000_0000;
            OFS_PLOCK:  rdata = idx_bpr ? plock_all[index_q[2:0]*32 +: 32] : 32'h0000_0000;
            OFS_SID:    rdata = sid_q[index_q];
            default:    rdata = 32'h0000_0000;
        endcase
    end

    // command acceptance; protect pin is no term for program or erase
    always_comb begin
        cmd_ok = 1'b0;
        case (cmd_code)
            CMD_NOP, CMD_WRITE_ENABLE_CMD, CMD_WRITE_DISABLE_CMD, CMD_QUAD_ON, CMD_QUAD_OFF: cmd_ok = !busy;
            CMD_RESET:   cmd_ok = 1'b1;
            CMD_WRITE_PROTECT_REG_CMD:    cmd_ok = !busy && wel_q && !lockdown_q && !wp_active;
            CMD_LOCK_PROTECTION_CMD:    cmd_ok = !busy && wel_q;
            CMD_PLOCK:   cmd_ok = !busy && wel_q && !lockdown_q;
            CMD_WCFG:    cmd_ok = !busy && wel_q && !wp_active;
            CMD_PROGRAM_SECID_CMD:    cmd_ok = !busy && wel_q && !sid_lock_q
                                  && (index_q >= 9'(SID_UID_WORDS));
            CMD_LOCKOUT_SECID_CMD:    cmd_ok = !busy && wel_q;
            CMD_PROG, CMD_ERASE:
                         cmd_ok = (state_q == FWP_IDLE) && wel_q && !blk_locked;
            CMD_SUSPEND: cmd_ok = (state_q == FWP_PROG) || (state_q == FWP_ERASE);
            CMD_RESUME:  cmd_ok = (state_q == FWP_PSUS) || (state_q == FWP_ESUS);
            default:     cmd_ok = 1'b0;
        endcase
    end

    assign go = cmd_vld & cmd_ok;

    // last command outcome, visible in the command register
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            refused_q <= 1'b0;
        end else if (clk_en && cmd_vld) begin
            refused_q <= ~cmd_ok;
        end
    end

    // software-side staging: index, block words, config and security-ID data
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            index_q     <= 9'h000;
            cfg_stage_q <= 8'h00;
            sid_data_q  <= 32'h0000_0000;
            for (int i = 0; i < BPR_WORDS; i++) begin
                stage_q[i] <= 32'h0000_0000;
            end
        end else if (clk_en && wb_wr) begin
            if (wb_adr_i == OFS_INDEX && wb_sel_i[0]) begin
                index_q[7:0] <= wb_dat_i[7:0];
            end
            if (wb_adr_i == OFS_INDEX && wb_sel_i[1]) begin
                index_q[8] <= wb_dat_i[8];
            end
            if (wb_adr_i == OFS_CONFIG && wb_sel_i[0]) begin
                cfg_stage_q <= wb_dat_i[7:0];
            end
            if (wb_adr_i == OFS_SID) begin
                sid_data_q <= (sid_data_q & ~wmask) | (wb_dat_i & wmask);
            end
            if ((wb_adr_i == OFS_BPR || wb_adr_i == OFS_PLOCK) && idx_bpr) begin
                stage_q[index_q[2:0]] <= (stage_q[index_q[2:0]] & ~wmask) | (wb_dat_i & wmask);
            end
        end
    end

    // write-enable latch; set only by the enable command
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            wel_q <= 1'b0;
        end else if (clk_en) begin
            if (go && cmd_code == CMD_WRITE_ENABLE_CMD) begin
                wel_q <= 1'b1;
            end else if ((go && (cmd_code == CMD_WRITE_DISABLE_CMD || cmd_code == CMD_SUSPEND
                                 || cmd_code == CMD_RESET))
                         || (cmd_vld && (cmd_code == CMD_WRITE_PROTECT_REG_CMD || cmd_code == CMD_LOCK_PROTECTION_CMD
                                         || cmd_code == CMD_WCFG || cmd_code == CMD_PLOCK))
                         || op_done || hold_reset) begin
                wel_q <= 1'b0;
            end
        end
    end

    // volatile lock-down, cleared only by power-up reset
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            lockdown_q <= 1'b0;
        end else if (clk_en && go && cmd_code == CMD_LOCK_PROTECTION_CMD) begin
            lockdown_q <= 1'b1;
        end
    end

    // volatile block-protect bits; permanent locks always or-ed back in
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            bpr_q <= BPR_RESET;
        end else if (clk_en && go) begin
            if (cmd_code == CMD_WRITE_PROTECT_REG_CMD) begin
                bpr_q <= {stage_all[BPR_W-1:PLOCK_W], stage_all[PLOCK_W-1:0] | plock_q};
            end else if (cmd_code == CMD_PLOCK) begin
                bpr_q[PLOCK_W-1:0] <= bpr_q[PLOCK_W-1:0] | stage_all[PLOCK_W-1:0];
            end
        end
    end

    // volatile configuration: io bit and quad command mode
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ioc_q  <= IOC_RESET;
            quad_q <= 1'b0;
        end else if (clk_en && go) begin
            if (cmd_code == CMD_WCFG) begin
                ioc_q <= cfg_stage_q[CFG_IOC];
            end
            if (cmd_code == CMD_QUAD_ON) begin
                quad_q <= 1'b1;
            end else if (cmd_code == CMD_QUAD_OFF || cmd_code == CMD_RESET) begin
                quad_q <= 1'b0;
            end
        end
    end

    // non-volatile state: only the factory reset clears it, power cycles do not
    always_ff @(posedge clock or negedge factory_rstn) begin
        if (!factory_rstn) begin
            pin_en_q   <= PIN_EN_RESET;
            plock_q    <= '0;
            sid_lock_q <= 1'b0;
            sid_q[0]   <= UNIQUE_ID[31:0];
            sid_q[1]   <= UNIQUE_ID[63:32];
            for (int i = SID_UID_WORDS; i < SID_WORDS; i++) begin
                sid_q[i] <= SID_BLANK;
            end
        end else if (clk_en) begin
            if (go && cmd_code == CMD_WCFG) begin
                pin_en_q <= cfg_stage_q[CFG_PIN_EN];
            end
            if (go && cmd_code == CMD_PLOCK) begin
                // ones only accumulate, zeros leave bits alone
                plock_q <= plock_q | stage_all[PLOCK_W-1:0];
            end
            if (go && cmd_code == CMD_PROGRAM_SECID_CMD) begin
                // programming only clears bits, no erase path exists
                sid_q[index_q] <= sid_q[index_q] & sid_data_q;
            end
            if (op_done && state_q == FWP_NV && sid_op_q) begin
                sid_lock_q <= 1'b1;
            end
        end
    end

    // sequencer for self-timed program, erase and non-volatile updates
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_q  <= FWP_IDLE;
            tmr_q    <= '0;
            sid_op_q <= 1'b0;
        end else if (clk_en) begin
            if (go && cmd_code == CMD_RESET) begin
                state_q <= FWP_IDLE;
                tmr_q   <= '0;
            end else if (go && (cmd_code == CMD_PROG || cmd_code == CMD_PROGRAM_SECID_CMD)) begin
                state_q  <= FWP_PROG;
                tmr_q    <= OP_CYCLES;
                sid_op_q <= cmd_code == CMD_PROGRAM_SECID_CMD;
            end else if (go && cmd_code == CMD_ERASE) begin
                state_q  <= FWP_ERASE;
                tmr_q    <= OP_CYCLES;
                sid_op_q <= 1'b0;
            end else if (go && (cmd_code == CMD_PLOCK || cmd_code == CMD_LOCKOUT_SECID_CMD
                                || (cmd_code == CMD_WCFG
                                    && cfg_stage_q[CFG_PIN_EN] != pin_en_q))) begin
                state_q  <= FWP_NV;
                tmr_q    <= NV_CYCLES;
                sid_op_q <= cmd_code == CMD_LOCKOUT_SECID_CMD;
            end else if (go && cmd_code == CMD_SUSPEND) begin
                // the timer keeps its remainder for the resume
                state_q <= (state_q == FWP_PROG) ? FWP_PSUS : FWP_ESUS;
            end else if (go && cmd_code == CMD_RESUME) begin
                state_q <= (state_q == FWP_PSUS) ? FWP_PROG : FWP_ERASE;
            end else if (op_done) begin
                state_q <= FWP_IDLE;
                tmr_q   <= '0;
            end else if (busy) begin
                tmr_q <= tmr_q - TMR_W'(1);
            end
        end
    end

    // pause: quad mode or io bit set keeps it off
    assign hold_en    = ~ioc_q & ~quad_q;
    assign hold_reset = hold_q & cs_sync_q[1] & ~cs_prev_q;

    // entry waits for a low clock phase; exit does too unless chip select is high
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            hold_q <= 1'b0;
        end else if (clk_en) begin
            if (!hold_en) begin
                hold_q <= 1'b0;
            end else if (!hold_q) begin
                hold_q <= ~cs_sync_q[1] & ~pause_sync_q[1] & ~sck_sync_q[1];
            end else if (pause_sync_q[1] && (!sck_sync_q[1] || cs_sync_q[1])) begin
                hold_q <= 1'b0;
            end
        end
    end

    assign serial_frozen = hold_q;

    // serial output released while paused; one flop of latency on data
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            so_out     <= 1'b0;
            so_oe      <= 1'b0;
            link_reset <= 1'b0;
        end else if (clk_en) begin
            so_out     <= so_data;
            so_oe      <= so_drive & ~hold_q & ~cs_sync_q[1];
            link_reset <= hold_reset;
        end
    end

endmodule

//--- design/fwp_pkg.sv
// constants, command codes and state type of the flash write-protect block
// Operation
// - enable write before lock-down; lock-down freezes block-protect
// - only power cycle clears lock-down; status shows it
// - permanent lock register holds 136 block bits
// - permanent lock bit forces block write-lock forever
// - zero written to permanent lock changes nothing
// - permanent lock write ignored during lock-down
// - pin low, io bit 0, pin-enable 1 blocks writes; code also requires quad command mode off
// - pin-enable 0 ignores the protect pin
// - io bit 1 disables protect pin entirely
// - protect pin never affects program or erase
// - lock-down forbids block-protect write regardless of pin
// - pin-enable non-volatile, factory value zero
// - 2 KByte security-ID, fixed 64-bit unique part
// - security-ID lockout rejects later security-ID writes
// - pause only in single/dual mode, io bit 0
// - pause starts and ends in clock low phase; code ends it at any clock phase while chip select is high
// - paused: output released, clock and input ignored
// - chip select rise while paused resets logic
// - status bit layout, all zero at power-up; code keeps bit 5 set through power-up once locked
// - busy shown at status bits 0 and 7
// - security-ID locked bit survives power-up once set
// - write latch clear refuses protected write commands
// - write latch cleared by listed events
// - block-protect write needs write-enable just before
// - configuration bit 7 is pin-enable
// - configuration bit 1 is io configuration
package fwp_pkg;
    // timing of internal self-timed operations
    localparam int unsigned CLK_MHZ     = 50;
    localparam int unsigned OP_TIME_US  = 20;
    localparam int unsigned NV_TIME_US  = 10;
    localparam int unsigned TMR_W       = 12;
    localparam logic [TMR_W-1:0] OP_CYCLES = TMR_W'(OP_TIME_US * CLK_MHZ);
    localparam logic [TMR_W-1:0] NV_CYCLES = TMR_W'(NV_TIME_US * CLK_MHZ);

    // storage sizes
    localparam int unsigned PLOCK_W       = 136;
    localparam int unsigned BPR_W         = 144;
    localparam int unsigned BPR_WORDS     = 5;
    localparam int unsigned SID_WORDS     = 512;
    localparam int unsigned SID_UID_WORDS = 2;
    localparam logic [BPR_W-1:0] BPR_RESET = {8'h00, {PLOCK_W{1'b1}}};
    localparam logic [31:0] SID_BLANK = 32'hffff_ffff;

    // register byte offsets
    localparam logic [7:0] OFS_STATUS = 8'h00;
    localparam logic [7:0] OFS_CONFIG = 8'h04;
    localparam logic [7:0] OFS_CMD    = 8'h08;
    localparam logic [7:0] OFS_INDEX  = 8'h0c;
    localparam logic [7:0] OFS_BPR    = 8'h10;
    localparam logic [7:0] OFS_PLOCK  = 8'h14;
    localparam logic [7:0] OFS_SID    = 8'h18;

    // field positions
    localparam int unsigned ST_BUSY_LO  = 0;
    localparam int unsigned ST_WEL      = 1;
    localparam int unsigned ST_ESUS     = 2;
    localparam int unsigned ST_PSUS     = 3;
    localparam int unsigned ST_LOCKDOWN = 4;
    localparam int unsigned ST_SECID    = 5;
    localparam int unsigned ST_BUSY_HI  = 7;
    localparam int unsigned CFG_IOC     = 1;
    localparam int unsigned CFG_VOLAT   = 3;
    localparam int unsigned CFG_PIN_EN  = 7;
    localparam int unsigned CMD_REFUSED = 0;
    localparam int unsigned CMD_QUAD    = 1;

    // values after reset
    localparam logic IOC_RESET    = 1'b0;
    localparam logic PIN_EN_RESET = 1'b0;

    // command codes written to the command register
    localparam logic [7:0] CMD_NOP      = 8'h00;
    localparam logic [7:0] CMD_WRITE_ENABLE_CMD     = 8'h01;
    localparam logic [7:0] CMD_WRITE_DISABLE_CMD     = 8'h02;
    localparam logic [7:0] CMD_WRITE_PROTECT_REG_CMD     = 8'h03;
    localparam logic [7:0] CMD_LOCK_PROTECTION_CMD     = 8'h04;
    localparam logic [7:0] CMD_PLOCK    = 8'h05;
    localparam logic [7:0] CMD_WCFG     = 8'h06;
    localparam logic [7:0] CMD_PROGRAM_SECID_CMD     = 8'h07;
    localparam logic [7:0] CMD_LOCKOUT_SECID_CMD     = 8'h08;
    localparam logic [7:0] CMD_PROG     = 8'h09;
    localparam logic [7:0] CMD_ERASE    = 8'h0a;
    localparam logic [7:0] CMD_SUSPEND  = 8'h0b;
    localparam logic [7:0] CMD_RESUME   = 8'h0c;
    localparam logic [7:0] CMD_RESET    = 8'h0d;
    localparam logic [7:0] CMD_QUAD_ON  = 8'h0e;
    localparam logic [7:0] CMD_QUAD_OFF = 8'h0f;

    // internal operation state
    typedef enum logic [5:0] {
        FWP_IDLE  = 6'b000001,
        FWP_PROG  = 6'b000010,
        FWP_ERASE = 6'b000100,
        FWP_NV    = 6'b001000,
        FWP_PSUS  = 6'b010000,
        FWP_ESUS  = 6'b100000
    } fwp_state_t;
endpackage

//--- sim/fwp_host_model.sv
// host controller pins: chip select, serial clock and pause
`timescale 1ns/1ps
module fwp_host_model (
    input  wire logic clock,
    output logic      chip_sel_n,
    output logic      serial_clk,
    output logic      pause_pin_n
);
    initial begin
        chip_sel_n = 1'b1;
        serial_clk = 1'b0;
        pause_pin_n = 1'b1;
    end
    // serial clock runs only inside a frame, idles low between frames
    always begin
        #80;
        serial_clk = !chip_sel_n ? ~serial_clk : 1'b0;
    end
    // select or deselect; resuming needs pause high before select
    task automatic frame(input logic on);
        @(posedge clock);
        chip_sel_n <= ~on;
    endtask
    // pause pin changes at any phase; device aligns to clock low
    task automatic hold(input logic v);
        @(posedge clock);
        pause_pin_n <= v;
    endtask
endmodule

//--- sim/fwp_monitor.sv
// assertion checker on the ports of the write-protect core
`timescale 1ns/1ps
module fwp_monitor
    import fwp_pkg::*;
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic pause_pin_n,
    input wire logic chip_sel_n,
    input wire logic so_oe,
    input wire logic serial_frozen,
    input wire logic link_reset
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    a_ack_single_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("bus ack held longer than one cycle");
    a_ack_next_cycle: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
        else $error("bus ack missing one cycle after request");
    a_ack_has_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("bus ack without request");
    a_paused_no_drive: assert property (serial_frozen [*2] |-> !so_oe)
        else $error("serial output driven while paused");
    a_deselect_no_drive: assert property (chip_sel_n [*5] |-> !so_oe)
        else $error("serial output driven while deselected");
    a_link_reset_pulse: assert property (link_reset |=> !link_reset)
        else $error("link reset longer than one cycle");
    a_link_reset_cause: assert property (link_reset |-> $past(serial_frozen))
        else $error("link reset outside pause");
    a_pause_entry_cause: assert property ($rose(serial_frozen) |->
        (!$past(pause_pin_n, 3) || !$past(pause_pin_n, 4)))
        else $error("pause entered without pause pin low");
endmodule

bind fwp_core fwp_monitor u_fwp_monitor (
    .clock(clock), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .pause_pin_n(pause_pin_n), .chip_sel_n(chip_sel_n),
    .so_oe(so_oe), .serial_frozen(serial_frozen), .link_reset(link_reset)
);

//--- sim/test_fwp_core.sv
// self-checking bench for the write-protect core
`timescale 1ns/1ps
module test_fwp_core
    import fwp_pkg::*;
;
    typedef struct packed {logic [7:0] c; logic [7:0] st; logic rf;} fwp_row_t;
    logic        clock = 1'b0;
    logic        rstn, frst, cyc, stb, we, protect_n, seen_lrst = 1'b0;
    logic        en = 1'b1, sod = 1'b1, sdrv = 1'b1;
    logic [3:0]  sel = 4'h0;
    logic [7:0]  adr;
    logic [31:0] wdat, rd, wb_dat_o;
    logic        wb_ack_o, so_out, so_oe, frozen, lrst, cs_n, sclk, pause_n;
    int          n_errors = 0;
    int          check_count = 0;
    int          cyc_n = 0;
    // lock-down sequence; refused commands still clear the latch
    fwp_row_t rows [10] = '{'{CMD_WRITE_ENABLE_CMD, 8'h02, 1'b0}, '{CMD_WRITE_DISABLE_CMD, 8'h00, 1'b0},
        '{CMD_LOCK_PROTECTION_CMD, 8'h00, 1'b1}, '{CMD_WRITE_ENABLE_CMD, 8'h02, 1'b0}, '{CMD_LOCK_PROTECTION_CMD, 8'h10, 1'b0},
        '{CMD_WRITE_ENABLE_CMD, 8'h12, 1'b0}, '{CMD_WRITE_PROTECT_REG_CMD, 8'h10, 1'b1}, '{CMD_WRITE_ENABLE_CMD, 8'h12, 1'b0},
        '{CMD_PLOCK, 8'h10, 1'b1}, '{8'h55, 8'h10, 1'b1}};

    fwp_core u_fwp_core (.clock(clock), .rstn(rstn), .factory_rstn(frst), .clk_en(en),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .protect_pin_n(protect_n), .pause_pin_n(pause_n), .chip_sel_n(cs_n),
        .serial_clk(sclk), .so_data(sod), .so_drive(sdrv), .so_out(so_out),
        .so_oe(so_oe), .serial_frozen(frozen), .link_reset(lrst));
    fwp_host_model u_fwp_host_model (.clock(clock), .chip_sel_n(cs_n),
        .serial_clk(sclk), .pause_pin_n(pause_n));

    always #10 clock = ~clock;
    // cycle ceiling and capture of the one-cycle link reset pulse
    always @(posedge clock) begin
        cyc_n++;
        if (lrst === 1'b1) seen_lrst <= 1'b1;
        if (cyc_n > 20000) begin
            n_errors++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        if (n_errors == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            n_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    // classic single cycle: hold until ack, then release for a cycle
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s = 4'hf);
        @(posedge clock);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
        sel <= s;
        // no local limit: only the bench's cycle ceiling ends a hung wait
        do begin
            @(posedge clock);
        end while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        cyc <= 1'b0; stb <= 1'b0;
    endtask
    task automatic cmd(input logic [7:0] c);
        wb(1'b1, OFS_CMD, {24'h0, c});
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    task automatic idle();
        int n = 0;
        do begin
            wb(1'b0, OFS_STATUS, 32'h0);
            n++;
        end while (rd[0] !== 1'b0 && n < 600);
    endtask
    task automatic pwr();
        @(posedge clock);
        rstn <= 1'b0;
        repeat (2) @(posedge clock);
        rstn <= 1'b1;
    endtask

    initial begin
        rstn = 0; frst = 0; cyc = 0; stb = 0; we = 0; adr = 0; wdat = 0;
        protect_n = 1;
        repeat (8) @(posedge clock);
        rstn <= 1'b1; frst <= 1'b1;
        foreach (rows[i]) begin
            cmd(rows[i].c);
            rchk(OFS_STATUS, {24'h0, rows[i].st});
            rchk(OFS_CMD, {31'h0, rows[i].rf});
        end
        pwr();
        rchk(OFS_STATUS, 32'h0);
        rchk(8'h40, 32'h0);
        // permanent lock forces the block write-lock and ignores zeros
        wb(1'b1, OFS_INDEX, 32'h0); wb(1'b1, OFS_BPR, 32'h0);
        cmd(CMD_WRITE_ENABLE_CMD); cmd(CMD_WRITE_PROTECT_REG_CMD);
        rchk(OFS_BPR, 32'h0);
        wb(1'b1, OFS_PLOCK, 32'h1); cmd(CMD_WRITE_ENABLE_CMD); cmd(CMD_PLOCK);
        rchk(OFS_STATUS, 32'h81);
        idle();
        rchk(OFS_PLOCK, 32'h1);
        wb(1'b1, OFS_BPR, 32'h0); cmd(CMD_WRITE_ENABLE_CMD); cmd(CMD_WRITE_PROTECT_REG_CMD);
        rchk(OFS_BPR, 32'h1);
        // protect pin enabled then held low
        wb(1'b1, OFS_CONFIG, 32'h80); cmd(CMD_WRITE_ENABLE_CMD); cmd(CMD_WCFG); idle();
        rchk(OFS_CONFIG, 32'h80);
        protect_n <= 1'b0;
        repeat (4) @(posedge clock);
        cmd(CMD_WRITE_ENABLE_CMD); cmd(CMD_WRITE_PROTECT_REG_CMD);
        rchk(OFS_CMD, 32'h1);
        cmd(CMD_WRITE_ENABLE_CMD); wb(1'b1, OFS_CONFIG, 32'h82); cmd(CMD_WCFG);
        rchk(OFS_CMD, 32'h1);
        wb(1'b1, OFS_INDEX, 32'h1); cmd(CMD_WRITE_ENABLE_CMD); cmd(CMD_PROG);
        rchk(OFS_CMD, 32'h0);
        // clock enable low freezes the program timer, so it is still busy after
        en <= 1'b0;
        repeat (1100) @(posedge clock);
        en <= 1'b1;
        rchk(OFS_STATUS, 32'h83);
        cmd(CMD_SUSPEND);
        rchk(OFS_STATUS, 32'h08);
        cmd(CMD_RESUME);
        idle();
        protect_n <= 1'b1;
        // security-ID lockout survives power cycling
        cmd(CMD_WRITE_ENABLE_CMD); cmd(CMD_LOCKOUT_SECID_CMD); idle();
        rchk(OFS_STATUS, 32'h20);
        pwr();
        rchk(OFS_STATUS, 32'h20);
        wb(1'b1, OFS_INDEX, 32'h2); wb(1'b1, OFS_SID, 32'h0);
        cmd(CMD_WRITE_ENABLE_CMD); cmd(CMD_PROGRAM_SECID_CMD);
        rchk(OFS_CMD, 32'h1);
        wb(1'b1, OFS_INDEX, 32'h1ff, 4'h2);
        rchk(OFS_INDEX, 32'h102);
        // pause inside a frame, then deselect while paused
        u_fwp_host_model.frame(1'b1);
        repeat (20) @(posedge clock);
        chk({31'h0, so_oe}, 32'h1);
        chk({31'h0, so_out}, 32'h1);
        sod <= 1'b0;
        sdrv <= 1'b0;
        repeat (3) @(posedge clock);
        chk({31'h0, so_out}, 32'h0);
        chk({31'h0, so_oe}, 32'h0);
        sdrv <= 1'b1;
        u_fwp_host_model.hold(1'b0);
        repeat (40) @(posedge clock);
        chk({31'h0, frozen}, 32'h1);
        chk({31'h0, so_oe}, 32'h0);
        u_fwp_host_model.frame(1'b0);
        repeat (10) @(posedge clock);
        chk({31'h0, seen_lrst}, 32'h1);
        u_fwp_host_model.hold(1'b1);
        repeat (10) @(posedge clock);
        chk({31'h0, frozen}, 32'h0);
        // quad command mode keeps pause off even with the pin low in a frame
        cmd(CMD_QUAD_ON);
        rchk(OFS_CMD, 32'h2);
        u_fwp_host_model.frame(1'b1);
        u_fwp_host_model.hold(1'b0);
        repeat (40) @(posedge clock);
        chk({31'h0, frozen}, 32'h0);
        end_of_test();
    end
endmodule
